//--- an_lt_pkg.sv
`default_nettype none
package an_lt_pkg;
    // widths of the control groups
    localparam int LANES     = 4;
    localparam int ABIL_W    = 15;
    localparam int SEED_W    = 11;
    localparam int COEF_W    = 2;
    localparam int FRAME_W   = 4;

    // bit positions of each protocol in the codeword ability field
    localparam int POS_1G_KX         = 0;
    localparam int POS_10G_4L_KX     = 1;
    localparam int POS_10G_KR        = 2;
    localparam int POS_40G_4L_KR     = 3;
    localparam int POS_40G_4L_CR     = 4;
    localparam int POS_100G_10L_CR   = 5;
    localparam int POS_100G_4L_KP    = 6;
    localparam int POS_100G_4L_KR    = 7;
    localparam int POS_100G_4L_CR    = 8;
    localparam int POS_25G_SHORT     = 9;
    localparam int POS_25G_FULL      = 10;
    localparam int POS_25G_1L_KR     = 11;
    localparam int POS_25G_1L_CR     = 12;
    localparam int POS_50G_2L_KR     = 13;
    localparam int POS_50G_2L_CR     = 14;

    // last count of a 16-cycle training frame, counter wraps at this value
    localparam logic [FRAME_W-1:0] FRAME_LAST = 4'hf;

    // values after reset
    localparam logic [ABIL_W-1:0]  ABIL_RST   = 15'h0000;
    localparam logic [SEED_W-1:0]  SEED_RST   = 11'h001;
    localparam logic [LANES-1:0]   LANES_RST  = 4'h0;
    localparam logic [3*COEF_W-1:0] COEF_RST  = 6'h00;

    // training sequencer states
    typedef enum logic [1:0] {
        ST_MISSION = 2'b00,
        ST_TRAIN   = 2'b01,
        ST_DONE    = 2'b10
    } train_state_e;
endpackage
`default_nettype wire

//--- pattern_if.sv
`default_nettype none
interface pattern_if;
    import an_lt_pkg::*;
    logic [SEED_W-1:0] seed;
    logic              load;
    logic              step;
    logic              pat_bit;
    logic [SEED_W-1:0] pat_state;

    modport gen  (input seed, load, step, output pat_bit, pat_state);
    modport user (output seed, load, step, input pat_bit, pat_state);
endinterface
`default_nettype wire

//--- lane0_pattern_gen.sv
`default_nettype none
module lane0_pattern_gen (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    pattern_if.gen     pat
);
    import an_lt_pkg::*;

    logic [SEED_W-1:0] lfsr;

    // an all-zero seed would freeze the generator, so it is replaced by one
    function automatic logic [SEED_W-1:0] safe_seed(input logic [SEED_W-1:0] s);
        safe_seed = (s == '0) ? SEED_RST : s;
    endfunction

    // x^11 + x^9 + 1 shift register; load wins over step
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lfsr <= SEED_RST;
        end else if (pat.load) begin
            lfsr <= safe_seed(pat.seed);
        end else if (pat.step) begin
            lfsr <= {lfsr[SEED_W-2:0], lfsr[SEED_W-1] ^ lfsr[SEED_W-3]};
        end
    end

    assign pat.pat_bit   = lfsr[SEED_W-1];
    assign pat.pat_state = lfsr;

    a_seed_load_taken : assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pat.load |=> lfsr == safe_seed($past(pat.seed)))
        else $error("pattern generator did not start from the seed");
endmodule
`default_nettype wire

//--- autoneg_link_training_ctl.sv
`default_nettype none
module autoneg_link_training_ctl (
    input  wire logic                             clk_i,
    input  wire logic                             sys_rst_i,
    input  wire logic                             adv_1g_kx_i,
    input  wire logic                             adv_10g_four_lane_kx_i,
    input  wire logic                             adv_10g_kr_i,
    input  wire logic                             adv_40g_four_lane_kr_i,
    input  wire logic                             adv_40g_four_lane_cr_i,
    input  wire logic                             adv_100g_ten_lane_cr_i,
    input  wire logic                             adv_100g_four_lane_kp_i,
    input  wire logic                             adv_100g_four_lane_kr_i,
    input  wire logic                             adv_100g_four_lane_cr_i,
    input  wire logic                             adv_25g_short_reach_i,
    input  wire logic                             adv_25g_full_reach_i,
    input  wire logic                             adv_25g_single_kr_i,
    input  wire logic                             adv_25g_single_cr_i,
    input  wire logic                             adv_50g_two_lane_kr_i,
    input  wire logic                             adv_50g_two_lane_cr_i,
    input  wire logic                             train_enable_in_i,
    input  wire logic                             train_restart_in_i,
    input  wire logic [an_lt_pkg::LANES-1:0]      receiver_done_in_i,
    input  wire logic [an_lt_pkg::LANES-1:0]      frame_preset_in_i,
    input  wire logic [an_lt_pkg::LANES-1:0]      frame_init_in_i,
    input  wire logic [an_lt_pkg::SEED_W-1:0]     lane0_pattern_seed_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_plus_req_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_center_req_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_minus_req_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_plus_stat_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_center_stat_i,
    input  wire logic [an_lt_pkg::COEF_W-1:0]     lane0_minus_stat_i,
    output logic      [an_lt_pkg::ABIL_W-1:0]     codeword_ability_o,
    output logic                                  training_active_o,
    output logic                                  training_done_o,
    output logic      [an_lt_pkg::LANES-1:0]      lane_mission_o,
    output logic      [an_lt_pkg::LANES-1:0]      lane_rx_trained_o,
    output logic                                  frame_start_o,
    output logic      [an_lt_pkg::LANES-1:0]      tx_preset_o,
    output logic      [an_lt_pkg::LANES-1:0]      tx_init_o,
    output logic      [3*an_lt_pkg::COEF_W-1:0]   lane0_ctrl_coef_o,
    output logic      [3*an_lt_pkg::COEF_W-1:0]   lane0_stat_coef_o,
    output logic                                  lane0_pattern_o
);
    import an_lt_pkg::*;

    train_state_e         state;
    train_state_e         next_state;
    logic [FRAME_W-1:0]   frame_cnt;
    logic [ABIL_W-1:0]    abil_vec;
    logic                 start_train;
    logic                 frame_edge;

    pattern_if pat ();

    lane0_pattern_gen u_pattern (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pat       (pat.gen)
    );

    // gather the protocol abilities into codeword bit order
    always_comb begin
        abil_vec                  = '0;
        abil_vec[POS_1G_KX]       = adv_1g_kx_i;
        abil_vec[POS_10G_4L_KX]   = adv_10g_four_lane_kx_i;
        abil_vec[POS_10G_KR]      = adv_10g_kr_i;
        abil_vec[POS_40G_4L_KR]   = adv_40g_four_lane_kr_i;
        abil_vec[POS_40G_4L_CR]   = adv_40g_four_lane_cr_i;
        abil_vec[POS_100G_10L_CR] = adv_100g_ten_lane_cr_i;
        abil_vec[POS_100G_4L_KP]  = adv_100g_four_lane_kp_i;
        abil_vec[POS_100G_4L_KR]  = adv_100g_four_lane_kr_i;
        abil_vec[POS_100G_4L_CR]  = adv_100g_four_lane_cr_i;
        abil_vec[POS_25G_SHORT]   = adv_25g_short_reach_i;
        abil_vec[POS_25G_FULL]    = adv_25g_full_reach_i;
        abil_vec[POS_25G_1L_KR]   = adv_25g_single_kr_i;
        abil_vec[POS_25G_1L_CR]   = adv_25g_single_cr_i;
        abil_vec[POS_50G_2L_KR]   = adv_50g_two_lane_kr_i;
        abil_vec[POS_50G_2L_CR]   = adv_50g_two_lane_cr_i;
    end

    // codeword ability field, registered so the codeword sees a stable word
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            codeword_ability_o <= ABIL_RST;
        end else begin
            codeword_ability_o <= abil_vec;
        end
    end

    // training starts on a restart or on enable rising out of mission mode
    assign start_train = train_enable_in_i &&
                         (train_restart_in_i || state == ST_MISSION);

    // sequencer: disable beats restart, restart beats completion
    always_comb begin
        next_state = state;
        if (!train_enable_in_i) begin
            next_state = ST_MISSION;
        end else if (start_train) begin
            next_state = ST_TRAIN;
        end else begin
            unique case (state)
                ST_MISSION: next_state = ST_TRAIN;
                ST_TRAIN: begin
                    if (&(lane_rx_trained_o | receiver_done_in_i)) begin
                        next_state = ST_DONE;
                    end
                end
                ST_DONE:    next_state = ST_DONE;
                default:    next_state = ST_MISSION;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_MISSION;
        end else begin
            state <= next_state;
        end
    end

    // per-lane receiver completion, sticky until the next training start or until training is disabled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lane_rx_trained_o <= LANES_RST;
        end else if (start_train || !train_enable_in_i) begin
            lane_rx_trained_o <= LANES_RST;
        end else if (state == ST_TRAIN) begin
            lane_rx_trained_o <= lane_rx_trained_o | receiver_done_in_i;
        end
    end

    // status levels; a lane leaves training only when the whole port does
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            training_active_o <= 1'b0;
            training_done_o   <= 1'b0;
            lane_mission_o    <= ~LANES_RST;
        end else begin
            training_active_o <= (next_state == ST_TRAIN);
            training_done_o   <= (next_state == ST_DONE);
            lane_mission_o    <= {LANES{next_state != ST_TRAIN}};
        end
    end

    // frame timer restarts with training so the first frame is a whole one
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_cnt <= '0;
        end else if (start_train || state != ST_TRAIN) begin
            frame_cnt <= '0;
        end else begin
            frame_cnt <= (frame_cnt == FRAME_LAST) ? '0 : frame_cnt + 4'h1;
        end
    end

    assign frame_edge = (state == ST_TRAIN) && !start_train && (frame_cnt == '0);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_start_o <= 1'b0;
        end else begin
            frame_start_o <= frame_edge;
        end
    end

    // control and status blocks snapped once per frame so a frame never mixes values
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_preset_o       <= LANES_RST;
            tx_init_o         <= LANES_RST;
            lane0_ctrl_coef_o <= COEF_RST;
            lane0_stat_coef_o <= COEF_RST;
        end else if (frame_edge) begin
            tx_preset_o       <= frame_preset_in_i;
            tx_init_o         <= frame_init_in_i;
            lane0_ctrl_coef_o <= {lane0_minus_req_i, lane0_center_req_i, lane0_plus_req_i};
            lane0_stat_coef_o <= {lane0_minus_stat_i,
                                  lane0_center_stat_i, lane0_plus_stat_i};
        end
    end

    // pattern generator reloads at every training start and runs while training
    assign pat.seed = lane0_pattern_seed_i;
    assign pat.load = start_train;
    assign pat.step = (state == ST_TRAIN);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lane0_pattern_o <= 1'b0;
        end else begin
            lane0_pattern_o <= (state == ST_TRAIN) ? pat.pat_bit : 1'b0;
        end
    end

    // helper for the frame-period check: cycles since the last frame start,
    // kept apart from frame_cnt so a wrong wrap point shows up
    logic [FRAME_W-1:0]   gap_cnt;
    logic                 gap_seen;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_cnt  <= '0;
            gap_seen <= 1'b0;
        end else if (state != ST_TRAIN || start_train) begin
            gap_cnt  <= '0;
            gap_seen <= 1'b0;
        end else if (frame_edge) begin
            gap_cnt  <= '0;
            gap_seen <= 1'b1;
        end else begin
            gap_cnt  <= gap_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ability_copied : assert property (##1 codeword_ability_o == $past(abil_vec))
        else $error("codeword ability bits do not follow inputs");
    a_disable_mission : assert property (!train_enable_in_i |=> lane_mission_o == 4'hf && !training_active_o)
        else $error("lanes not in mission mode while training disabled");
    a_restart_retrain : assert property (train_enable_in_i && train_restart_in_i
        |=> training_active_o && state == ST_TRAIN && frame_cnt == '0)
        else $error("restart did not return training to its start");
    a_preset_frame : assert property (frame_edge |=> tx_preset_o == $past(frame_preset_in_i))
        else $error("preset bits not taken at frame start");
    a_init_frame : assert property (frame_edge |=> tx_init_o == $past(frame_init_in_i))
        else $error("initialize bits not taken at frame start");
    a_coef_request : assert property (frame_edge |=> lane0_ctrl_coef_o ==
        $past({lane0_minus_req_i, lane0_center_req_i, lane0_plus_req_i}))
        else $error("coefficient requests not placed in control block");
    a_stat_plus_center : assert property (frame_edge |=>
        lane0_stat_coef_o[3:0] == $past({lane0_center_stat_i, lane0_plus_stat_i}))
        else $error("plus or center status not placed in status block");
    a_stat_minus : assert property (frame_edge |=> lane0_stat_coef_o[5:4] == $past(lane0_minus_stat_i))
        else $error("minus status not placed in status block");
    a_lane_done_map : assert property (state == ST_TRAIN && !start_train && train_enable_in_i
        && receiver_done_in_i[2] |=> lane_rx_trained_o[2])
        else $error("receiver done bit not mapped to its lane");
    a_frame_period : assert property (gap_seen && state == ST_TRAIN && !start_train
        |-> frame_edge == (gap_cnt == FRAME_LAST))
        else $error("training frame period is wrong");
    a_pattern_reload : assert property (start_train && lane0_pattern_seed_i != '0
        |=> pat.pat_state == $past(lane0_pattern_seed_i))
        else $error("lane-0 pattern did not restart from its seed");

    c_training_done : cover property (training_active_o ##[1:200] training_done_o);
    c_restart_mid   : cover property (training_active_o && train_restart_in_i && train_enable_in_i);
    c_two_frames    : cover property (frame_start_o ##16 frame_start_o);
    c_disable_train : cover property (training_active_o ##1 !train_enable_in_i);
endmodule
`default_nettype wire

//--- lane_ctl_model.sv
`default_nettype none
// outside controller: reports receiver training done per lane after a delay
module lane_ctl_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] want_i,
    input  wire logic [3:0] delay_i,
    output logic      [3:0] done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt [4];

    // lane n answers delay_i+n cycles late, so lanes finish at different times
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= 4'h0;
            for (int n = 0; n < 4; n++) cnt[n] <= 5'h00;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (!want_i[n]) begin
                    cnt[n]    <= 5'(delay_i) + 5'(n);
                    done_o[n] <= 1'b0;
                end else if (cnt[n] != 5'h00) begin
                    cnt[n] <= cnt[n] - 5'h01;
                end else begin
                    done_o[n] <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_autoneg_link_training_ctl.sv
`default_nettype none
module tb_autoneg_link_training_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    import an_lt_pkg::*;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [ABIL_W-1:0] abil = '0;
    logic              en = 1'b0;
    logic              rs = 1'b0;
    logic [3:0]        want = '0, pre = '0, ini = '0, rxd, tpre, tini, mis, trn;
    logic [SEED_W-1:0] seed = 11'h001;
    logic [1:0]        pr = '0, cr = '0, mr = '0, ps = '0, cs = '0, ms = '0;
    logic [ABIL_W-1:0] cw;
    logic [5:0]        ctl, stt;
    logic              act, dne, fs, pat;
    int                fails = 0;
    int                total_checks = 0;
    int                n;
    logic [23:0]       pa, pb;

    initial forever #2 clk_i = ~clk_i;

    lane_ctl_model u_lane_ctl_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .want_i(want), .delay_i(4'h2), .done_o(rxd));

    autoneg_link_training_ctl u_autoneg_link_training_ctl (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .adv_1g_kx_i(abil[POS_1G_KX]), .adv_10g_four_lane_kx_i(abil[POS_10G_4L_KX]),
        .adv_10g_kr_i(abil[POS_10G_KR]), .adv_40g_four_lane_kr_i(abil[POS_40G_4L_KR]),
        .adv_40g_four_lane_cr_i(abil[POS_40G_4L_CR]), .adv_100g_ten_lane_cr_i(abil[POS_100G_10L_CR]),
        .adv_100g_four_lane_kp_i(abil[POS_100G_4L_KP]), .adv_100g_four_lane_kr_i(abil[POS_100G_4L_KR]),
        .adv_100g_four_lane_cr_i(abil[POS_100G_4L_CR]), .adv_25g_short_reach_i(abil[POS_25G_SHORT]),
        .adv_25g_full_reach_i(abil[POS_25G_FULL]), .adv_25g_single_kr_i(abil[POS_25G_1L_KR]),
        .adv_25g_single_cr_i(abil[POS_25G_1L_CR]), .adv_50g_two_lane_kr_i(abil[POS_50G_2L_KR]),
        .adv_50g_two_lane_cr_i(abil[POS_50G_2L_CR]),
        .train_enable_in_i(en), .train_restart_in_i(rs), .receiver_done_in_i(rxd),
        .frame_preset_in_i(pre), .frame_init_in_i(ini), .lane0_pattern_seed_i(seed),
        .lane0_plus_req_i(pr), .lane0_center_req_i(cr), .lane0_minus_req_i(mr),
        .lane0_plus_stat_i(ps), .lane0_center_stat_i(cs), .lane0_minus_stat_i(ms),
        .codeword_ability_o(cw), .training_active_o(act), .training_done_o(dne),
        .lane_mission_o(mis), .lane_rx_trained_o(trn), .frame_start_o(fs),
        .tx_preset_o(tpre), .tx_init_o(tini), .lane0_ctrl_coef_o(ctl),
        .lane0_stat_coef_o(stt), .lane0_pattern_o(pat));

    task complete_run;
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // counts cycles up to the next frame start; a missing frame ends the run
    task wait_frame(output int c);
        c = 0;
        do begin tick(1); c++; end while (fs !== 1'b1 && c < 40);
        if (fs !== 1'b1) begin fails++; complete_run(); end
    endtask

    task restart_pulse;
        @(posedge clk_i) rs <= 1'b1;
        @(posedge clk_i) rs <= 1'b0;
    endtask

    task t_idle;
        n = 0;
        repeat (20) begin tick(1); if (fs !== 1'b0) n++; end
        check("mission", mis, 4'hf);
        check("active", act, 1'b0);
        check("frames", n, 0);
        restart_pulse();
        tick(3);
        check("restart_off", act, 1'b0);
    endtask

    task t_ability;
        for (int i = 0; i <= ABIL_W; i++) begin
            @(posedge clk_i) abil <= (i == ABIL_W) ? '1 : ABIL_W'(1) << i;
            tick(1);
            check("ability", cw, (i == ABIL_W) ? {ABIL_W{1'b1}} : ABIL_W'(1) << i);
        end
    endtask

    task t_frame;
        @(posedge clk_i) begin
            pre <= 4'h5; ini <= 4'ha; pr <= 2'd1; cr <= 2'd2; mr <= 2'd3;
            ps <= 2'd2; cs <= 2'd3; ms <= 2'd1; en <= 1'b1;
        end
        tick(3);
        check("active_on", act, 1'b1);
        check("mission_off", mis, 4'h0);
        wait_frame(n);
        check("preset", tpre, 4'h5);
        check("init", tini, 4'ha);
        check("ctrl", ctl, 6'h39);
        check("stat", stt, 6'h1e);
        @(posedge clk_i) begin pre <= 4'h8; ini <= 4'h1; pr <= 2'd2; mr <= 2'd0; ms <= 2'd2; cs <= 2'd0; end
        tick(3);
        check("preset_hold", tpre, 4'h5);
        wait_frame(n);
        // one edge and three ticks passed between the two frame starts before the count began
        check("frame_len", n + 4, FRAME_LAST + 1);
        check("preset2", tpre, 4'h8);
        check("init2", tini, 4'h1);
        check("ctrl2", ctl, 6'h0a);
        check("stat2", stt, 6'h22);
    endtask

    task t_restart;
        @(posedge clk_i) want <= 4'h3;
        tick(12);
        check("lanes_part", trn, 4'h3);
        check("not_done", dne, 1'b0);
        @(posedge clk_i) want <= 4'h0;
        restart_pulse();
        tick(3);
        check("lanes_clear", trn, 4'h0);
        @(posedge clk_i) rs <= 1'b1;
        n = 0;
        repeat (24) begin tick(1); if (fs !== 1'b0) n++; end
        check("held_frames", n, 0);
        @(posedge clk_i) rs <= 1'b0;
        wait_frame(n);
        check("first_frame", n, 1);
    endtask

    task grab(output logic [23:0] v);
        wait_frame(n);
        repeat (24) begin tick(1); v = {v[22:0], pat}; end
    endtask

    task t_pattern;
        @(posedge clk_i) seed <= 11'h2b5;
        restart_pulse();
        grab(pa);
        restart_pulse();
        grab(pb);
        check("pattern_rpt", pb, pa);
        @(posedge clk_i) seed <= 11'h4a3;
        restart_pulse();
        grab(pb);
        check("pattern_seed", pb != pa, 1'b1);
    endtask

    task t_done;
        @(posedge clk_i) want <= 4'hf;
        n = 0;
        do begin tick(1); n++; end while (dne !== 1'b1 && n < 30);
        check("done", dne, 1'b1);
        if (dne !== 1'b1) complete_run();
        check("mission_done", mis, 4'hf);
        @(posedge clk_i) en <= 1'b0;
        tick(3);
        check("disabled", act, 1'b0);
        check("mission_dis", mis, 4'hf);
        check("pattern_off", pat, 1'b0);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_idle();
        t_ability();
        t_frame();
        t_restart();
        t_pattern();
        t_done();
        complete_run();
    end
endmodule
`default_nettype wire
